// ==== include/cwd_consts.vh ====
// Purpose: Constants for the configuration word decoder
// Assumes: 25 MHz system clock, 16-bit configuration words
// Notes: Word indices match the stored word offsets; byte address is four times the index
`ifndef CWD_CONSTS_VH
`define CWD_CONSTS_VH

`define CWD_IDX_CFG2 16'h8008
`define CWD_IDX_CFG3 16'h8009
`define CWD_IDX_CTRL 16'h8010
`define CWD_IDX_STAT 16'h8011
`define CWD_IDX_PPS 16'h8012
`define CWD_IDX_WDT 16'h8013
`define CWD_ERASED 16'hFFFF

`define CWD_B_DEBUG 13
`define CWD_B_STACK 12
`define CWD_B_PPS1W 11
`define CWD_B_ZC_DIS 10
`define CWD_B_BOR_LVL 9
`define CWD_B_DACAUTO 8
`define CWD_F_BOR_MODE_HI 7
`define CWD_F_BOR_MODE_LO 6
`define CWD_F_PWRT_HI 2
`define CWD_F_PWRT_LO 1
`define CWD_B_MCLR_EN 0

`define CWD_F_WCCS_HI 13
`define CWD_F_WCCS_LO 11
`define CWD_F_WCWS_HI 10
`define CWD_F_WCWS_LO 8
`define CWD_F_WDOG_MODE_HI 6
`define CWD_F_WDOG_MODE_LO 5
`define CWD_F_WCPS_HI 4
`define CWD_F_WCPS_LO 0

`define CWD_EXT_HS 3'h2
`define CWD_EXT_XT 3'h1
`define CWD_EXT_LP 3'h0
`define CWD_CCS_SW 3'h7
`define CWD_WIN_SW 3'h7
`define CWD_WIN_OPEN_MIN 3'h6
`define CWD_CPS_SW 5'h1F
`define CWD_PS_DEFAULT 5'h0B
`define CWD_MODE_ON 2'h3
`define CWD_MODE_AWAKE 2'h2
`define CWD_MODE_SW 2'h1
`define CWD_MODE_OFF 2'h0

`define CWD_CLK_MHZ 25
`define CWD_PWRT_LONG_MS 64
`define CWD_PWRT_MID_MS 16
`define CWD_PWRT_SHORT_MS 1

`endif

// ==== core/cwd_pwrt.v ====
// Purpose: Power-up delay counter selected by configuration
// Assumes: i_start pulses once when the configuration is latched
// Notes: Counts are parameters so a bench can shorten them
`timescale 1ns/1ns
`include "cwd_consts.vh"
module cwd_pwrt #(
  parameter [23:0] LONG_CYC = `CWD_PWRT_LONG_MS * `CWD_CLK_MHZ * 1000,
  parameter [23:0] MID_CYC = `CWD_PWRT_MID_MS * `CWD_CLK_MHZ * 1000,
  parameter [23:0] SHORT_CYC = `CWD_PWRT_SHORT_MS * `CWD_CLK_MHZ * 1000
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_ce,
  input wire i_start,
  input wire [1:0] i_sel,
  output reg o_done
);
  reg [23:0] cnt_r;
  reg run_r;
  always @(posedge i_clk) begin
    if (i_srst) begin
      cnt_r <= 24'h000000;
      run_r <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      if (i_start) begin
        o_done <= 1'b0;
        run_r <= 1'b1;
        case (i_sel)
          2'h3: cnt_r <= 24'h000000;
          2'h2: cnt_r <= LONG_CYC - 24'h000001;
          2'h1: cnt_r <= MID_CYC - 24'h000001;
          default: cnt_r <= SHORT_CYC - 24'h000001;
        endcase
      end else if (run_r) begin
        if (cnt_r == 24'h000000) begin
          run_r <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 24'h000001;
        end
      end
    end
  end
endmodule

// ==== core/cwd_top.v ====
// Purpose: Decode configuration words two and three into static controls
// Assumes: Classic Wishbone slave, 32-bit data, byte address = 4 * index
// Notes: Words are latched from the stored image while reset is held
// Function
// - External oscillator code 010 HS, 001 XT, 000 LP crystal
// - Debugger enable bit 13 is active low; keep 1 normally
// - Stack fault reset bit gates stack faults into device reset
// - One-way option: lock sets once; otherwise set and clear after unlock
// - Zero-cross disable 1 needs software enable; 0 forces detector on
// - Brown-out level bit picks 1.9V when 1, 2.65V when 0
// - DAC auto bit 1 uses range bit; 0 hardware picks range
// - Brown-out mode 11 on, 10 awake only, 01 software, 00 off
// - Power-up delay 11 none, 10 64 ms, 01 16 ms, 00 1 ms
// - Reset pin is master clear under low-voltage programming or enable bit
// - Watchdog clock 111 software, 010 secondary, 001 mid, 000 low osc
// - Window codes set closed percent; 111 software changeable; low codes keyed
// - Watchdog mode 11 on, 10 awake, 01 software, 00 off
// - Period code 11111 resets runtime period to 01011, software changeable
`timescale 1ns/1ns
`include "cwd_consts.vh"
module cwd_top (
  input wire i_clk,
  input wire i_srst,
  input wire i_ce,
  input wire [15:0] i_cfg2_img,
  input wire [15:0] i_cfg3_img,
  input wire [2:0] i_ext_osc_mode_sel,
  input wire i_low_volt_prog_en,
  input wire i_stack_fault,
  input wire i_sleep,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [17:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  output reg [1:0] o_ext_osc_kind,
  output reg o_debug_en,
  output reg o_stack_reset,
  output reg o_pin_select_locked,
  output reg o_zero_cross_on,
  output reg o_brownout_high_level,
  output reg o_dac_range_manual,
  output reg o_dac_range,
  output reg o_brownout_en,
  output reg o_mclr_pin_is_reset,
  output reg o_powerup_done,
  output reg o_watchdog_en,
  output reg [2:0] o_watchdog_clock,
  output reg [2:0] o_watchdog_window,
  output reg [4:0] o_watchdog_runtime_period
);
  reg [15:0] cfg2_r;
  reg [15:0] cfg3_r;
  reg [2:0] ext_r;
  reg low_volt_prog_en_r;
  reg fault_s1_r;
  reg fault_s2_r;
  reg sleep_s1_r;
  reg sleep_s2_r;
  reg srst_d_r;
  reg pps_unlock_r;
  reg pps_lock_r;
  reg pps_once_r;
  reg zero_cross_sw_enable_r;
  reg zero_cross_module_disable_r;
  reg brownout_sw_enable_r;
  reg dac_range_bit_r;
  reg watchdog_sw_enable_r;
  reg [2:0] wdt_clk_sw_r;
  reg [2:0] wdt_win_r;
  reg [4:0] wdt_ps_r;
  reg key_r;
  wire [15:0] idx = i_wb_adr[17:2];
  wire acc = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wr = acc & i_wb_we & i_wb_sel[0];
  wire wr_hi = acc & i_wb_we & i_wb_sel[1];
  wire pwrt_done;
  wire [1:0] bor_mode = cfg2_r[`CWD_F_BOR_MODE_HI:`CWD_F_BOR_MODE_LO];
  wire [1:0] wdt_mode = cfg3_r[`CWD_F_WDOG_MODE_HI:`CWD_F_WDOG_MODE_LO];
  wire [2:0] ccs = cfg3_r[`CWD_F_WCCS_HI:`CWD_F_WCCS_LO];
  wire [2:0] cws = cfg3_r[`CWD_F_WCWS_HI:`CWD_F_WCWS_LO];
  wire [4:0] cps = cfg3_r[`CWD_F_WCPS_HI:`CWD_F_WCPS_LO];
  wire start = srst_d_r & ~i_srst;
  reg [31:0] rd_nxt;

  cwd_pwrt u_pwrt (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_start(start),
    .i_sel(cfg2_r[`CWD_F_PWRT_HI:`CWD_F_PWRT_LO]),
    .o_done(pwrt_done)
  );

  // Latch words while reset is held; synchronous reset only takes constants
  always @(posedge i_clk) begin
    if (i_ce) begin
      srst_d_r <= i_srst;
      fault_s1_r <= i_stack_fault;
      fault_s2_r <= fault_s1_r;
      sleep_s1_r <= i_sleep;
      sleep_s2_r <= sleep_s1_r;
      if (i_srst) begin
        cfg2_r <= i_cfg2_img;
        cfg3_r <= i_cfg3_img;
        ext_r <= i_ext_osc_mode_sel;
        low_volt_prog_en_r <= i_low_volt_prog_en;
      end
    end
  end

  // Software-side control registers
  always @(posedge i_clk) begin
    if (i_srst) begin
      pps_unlock_r <= 1'b0;
      pps_lock_r <= 1'b0;
      pps_once_r <= 1'b0;
      zero_cross_sw_enable_r <= 1'b0;
      zero_cross_module_disable_r <= 1'b0;
      brownout_sw_enable_r <= 1'b1;
      dac_range_bit_r <= 1'b0;
      watchdog_sw_enable_r <= 1'b0;
      wdt_clk_sw_r <= 3'h0;
      wdt_win_r <= 3'h7;
      wdt_ps_r <= 5'h00;
      key_r <= 1'b0;
    end else if (i_ce) begin
      if (start) begin
        wdt_win_r <= (cws >= `CWD_WIN_OPEN_MIN) ? 3'h7 : cws;
        wdt_ps_r <= (cps == `CWD_CPS_SW) ? `CWD_PS_DEFAULT : cps;
      end
      if (wr && idx == `CWD_IDX_PPS) begin
        pps_unlock_r <= i_wb_dat[2];
        if (pps_unlock_r && !(pps_once_r && cfg2_r[`CWD_B_PPS1W])) begin
          pps_lock_r <= i_wb_dat[0];
          if (i_wb_dat[0])
            pps_once_r <= 1'b1;
        end
      end else if (wr && idx == `CWD_IDX_CTRL) begin
        zero_cross_sw_enable_r <= i_wb_dat[0];
        zero_cross_module_disable_r <= i_wb_dat[1];
        brownout_sw_enable_r <= i_wb_dat[2];
        dac_range_bit_r <= i_wb_dat[3];
        watchdog_sw_enable_r <= i_wb_dat[4];
      end else if (wr && idx == `CWD_IDX_WDT) begin
        key_r <= i_wb_dat[7];
        if (ccs == `CWD_CCS_SW)
          wdt_clk_sw_r <= i_wb_dat[2:0];
        if (cps == `CWD_CPS_SW && wr_hi)
          wdt_ps_r <= i_wb_dat[12:8];
        if (cws == `CWD_WIN_SW || (cws <= 3'h3 && key_r))
          wdt_win_r <= i_wb_dat[6:4];
      end
    end
  end

  // Register reads
  always @* begin
    rd_nxt = 32'h00000000;
    if (idx == `CWD_IDX_CFG2)
      rd_nxt = {16'h0000, cfg2_r};
    else if (idx == `CWD_IDX_CFG3)
      rd_nxt = {16'h0000, cfg3_r};
    else if (idx == `CWD_IDX_CTRL)
      rd_nxt = {27'h0000000, watchdog_sw_enable_r, dac_range_bit_r, brownout_sw_enable_r,
                zero_cross_module_disable_r, zero_cross_sw_enable_r};
    else if (idx == `CWD_IDX_STAT)
      rd_nxt = {25'h0000000, o_watchdog_en, o_brownout_en, o_powerup_done,
                o_mclr_pin_is_reset, o_zero_cross_on, pps_once_r, pps_lock_r};
    else if (idx == `CWD_IDX_PPS)
      rd_nxt = {29'h00000000, pps_unlock_r, 1'b0, pps_lock_r};
    else if (idx == `CWD_IDX_WDT)
      rd_nxt = {19'h00000, wdt_ps_r, key_r, wdt_win_r, 1'b0, o_watchdog_clock};
  end

  // Bus answer and decoded outputs
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      o_ext_osc_kind <= 2'h3;
      o_debug_en <= 1'b0;
      o_stack_reset <= 1'b0;
      o_pin_select_locked <= 1'b0;
      o_zero_cross_on <= 1'b0;
      o_brownout_high_level <= 1'b0;
      o_dac_range_manual <= 1'b1;
      o_dac_range <= 1'b0;
      o_brownout_en <= 1'b0;
      o_mclr_pin_is_reset <= 1'b1;
      o_powerup_done <= 1'b0;
      o_watchdog_en <= 1'b0;
      o_watchdog_clock <= 3'h7;
      o_watchdog_window <= 3'h7;
      o_watchdog_runtime_period <= 5'h00;
    end else if (i_ce) begin
      o_wb_ack <= acc;
      o_wb_dat <= acc ? rd_nxt : 32'h00000000;
      if (ext_r == `CWD_EXT_HS)
        o_ext_osc_kind <= 2'h2;
      else if (ext_r == `CWD_EXT_XT)
        o_ext_osc_kind <= 2'h1;
      else if (ext_r == `CWD_EXT_LP)
        o_ext_osc_kind <= 2'h0;
      else
        o_ext_osc_kind <= 2'h3;
      o_debug_en <= ~cfg2_r[`CWD_B_DEBUG];
      o_stack_reset <= cfg2_r[`CWD_B_STACK] & fault_s2_r;
      o_pin_select_locked <= pps_lock_r;
      o_zero_cross_on <= cfg2_r[`CWD_B_ZC_DIS] ? zero_cross_sw_enable_r : 1'b1;
      o_brownout_high_level <= ~cfg2_r[`CWD_B_BOR_LVL];
      o_dac_range_manual <= cfg2_r[`CWD_B_DACAUTO];
      o_dac_range <= cfg2_r[`CWD_B_DACAUTO] ? dac_range_bit_r : 1'b0;
      case (bor_mode)
        `CWD_MODE_ON: o_brownout_en <= 1'b1;
        `CWD_MODE_AWAKE: o_brownout_en <= ~sleep_s2_r;
        `CWD_MODE_SW: o_brownout_en <= brownout_sw_enable_r;
        default: o_brownout_en <= 1'b0;
      endcase
      o_mclr_pin_is_reset <= low_volt_prog_en_r | cfg2_r[`CWD_B_MCLR_EN];
      o_powerup_done <= pwrt_done;
      case (wdt_mode)
        `CWD_MODE_ON: o_watchdog_en <= 1'b1;
        `CWD_MODE_AWAKE: o_watchdog_en <= ~sleep_s2_r;
        `CWD_MODE_SW: o_watchdog_en <= watchdog_sw_enable_r;
        default: o_watchdog_en <= 1'b0;
      endcase
      o_watchdog_clock <= (ccs == `CWD_CCS_SW) ? wdt_clk_sw_r : ccs;
      o_watchdog_window <= wdt_win_r;
      o_watchdog_runtime_period <= wdt_ps_r;
    end
  end
endmodule

// ==== tb/cwd_top_chk.sv ====
// Purpose: Port-level checker for the configuration word decoder
// Assumes: Clock enable held high by the bench
// Notes: Bound into every instance of the decoder top
`timescale 1ns/1ns
module cwd_chk (
  input wire i_clk,
  input wire i_srst,
  input wire i_ce,
  input wire [15:0] i_cfg2_img,
  input wire i_stack_fault,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire o_wb_ack,
  input wire [1:0] o_ext_osc_kind,
  input wire o_debug_en,
  input wire o_stack_reset,
  input wire o_brownout_high_level,
  input wire o_dac_range_manual,
  input wire o_mclr_pin_is_reset,
  input wire o_powerup_done,
  input wire [2:0] o_watchdog_window
);
  reg [2:0] run_cnt_r;
  reg [15:0] cfg2_r;
  // Cycles since release and the word latched during reset
  always @(posedge i_clk) begin
    if (i_srst) begin
      run_cnt_r <= 3'h0;
      cfg2_r <= i_cfg2_img;
    end else if (run_cnt_r != 3'h4) begin
      run_cnt_r <= run_cnt_r + 3'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence wb_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce;
  endsequence
  sequence wb_reply;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  wb_ack_reply_a: assert property (wb_take |=> wb_reply) else $error("no single ack");
  wb_ack_idle_a: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack) else $error("stray ack");
  reset_value_a: assert property (disable iff (1'b0) i_srst && i_ce |=> !o_wb_ack &&
    o_ext_osc_kind == 2'h3 && o_watchdog_window == 3'h7 && o_mclr_pin_is_reset)
    else $error("bad reset value");
  cfg_static_a: assert property (run_cnt_r == 3'h4 |-> $stable(o_debug_en) &&
    $stable(o_mclr_pin_is_reset) && $stable(o_ext_osc_kind) && $stable(o_dac_range_manual))
    else $error("config output moved");
  window_open_a: assert property (run_cnt_r == 3'h4 |-> o_watchdog_window != 3'h6)
    else $error("window code six");
  stack_quiet_a: assert property (!i_stack_fault [*4] |=> !o_stack_reset)
    else $error("stack reset without fault");
  powerup_hold_a: assert property (o_powerup_done |=> o_powerup_done)
    else $error("power-up done fell");
  debug_polarity_a: assert property (run_cnt_r == 3'h4 |-> o_debug_en == !cfg2_r[13])
    else $error("debug polarity");
  bor_level_a: assert property (run_cnt_r == 3'h4 |-> o_brownout_high_level == !cfg2_r[9])
    else $error("brown-out level");
endmodule
bind cwd_top cwd_chk u_chk (.*);

// ==== tb/cwd_top_test.sv ====
// Purpose: Self-checking bench for the configuration word decoder
// Assumes: Sleep pulsed once per test, Wishbone reply within 20 cycles
// Notes: Random words from a fixed seed plus erased and all-zero corners
`timescale 1ns/1ns
`include "cwd_consts.vh"
module cwd_top_test;
  logic i_clk = 1'h0, i_srst = 1'h1, i_ce = 1'h1, i_low_volt_prog_en = 1'h0;
  logic i_stack_fault = 1'h0, i_sleep = 1'h0, i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
  logic [15:0] i_cfg2_img = 16'h0, i_cfg3_img = 16'h0;
  logic [2:0] i_ext_osc_mode_sel = 3'h0;
  logic [17:0] i_wb_adr = 18'h0;
  logic [3:0] i_wb_sel = 4'hF;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd, a, b;
  logic o_wb_ack, o_debug_en, o_stack_reset, o_pin_select_locked, o_zero_cross_on;
  logic o_brownout_high_level, o_dac_range_manual, o_dac_range, o_brownout_en;
  logic o_mclr_pin_is_reset, o_powerup_done, o_watchdog_en;
  logic [1:0] o_ext_osc_kind;
  logic [2:0] o_watchdog_clock, o_watchdog_window;
  logic [4:0] o_watchdog_runtime_period;
  int fails = 0, cmp_count = 0, seed = 69, up_cyc = 0;
  cwd_top dut (.*);
  initial forever #20 i_clk = ~i_clk;
  // Edges since reset release
  always @(posedge i_clk) up_cyc <= i_srst ? 0 : up_cyc + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= we;
    i_wb_adr <= {idx, 2'h0};
    i_wb_dat <= d;
    i_wb_sel <= 4'hF;
    @(posedge i_clk);
    while (o_wb_ack !== 1'h1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    rd = o_wb_dat;
    if (n == 20) begin
      fails++;
      complete_run();
    end
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
    @(posedge i_clk);
  endtask
  function automatic logic [31:0] exp_f(input logic [15:0] c2, input logic [15:0] c3,
    input logic [2:0] osc, input logic lv);
    logic [2:0] w;
    w = (c3[10:8] > 3'h5) ? 3'h7 : c3[10:8];
    return {13'h0, (osc > 3'h2) ? 2'h3 : osc[1:0], ~c2[13], ~c2[9], c2[8], lv | c2[0], w,
      (c3[4:0] == 5'h1F) ? 5'h0B : c3[4:0], c2[7:6] != 2'h0, c3[6],
      ((c3[13:11] == 3'h7) ? 3'h0 : c3[13:11])};
  endfunction
  task automatic run(input logic [15:0] c2, input logic [15:0] c3);
    logic [31:0] m, g, d;
    logic [2:0] osc;
    osc = $random(seed);
    i_cfg2_img <= c2;
    i_cfg3_img <= c3;
    i_ext_osc_mode_sel <= osc;
    i_low_volt_prog_en <= osc[0] ^ c3[0];
    i_srst <= 1'h1;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'h0;
    @(posedge i_clk);
    i_cfg2_img <= ~c2;
    i_cfg3_img <= ~c3;
    repeat (4) @(posedge i_clk);
    m = {28'hFFFFFFF, c3[6:5] != 2'h1,
      {3{c3[6:5] != 2'h0 && (c3[13:11] < 3'h3 || c3[13:11] == 3'h7)}}};
    g = {13'h0, o_ext_osc_kind, o_debug_en, o_brownout_high_level, o_dac_range_manual,
      o_mclr_pin_is_reset, o_watchdog_window, o_watchdog_runtime_period, o_brownout_en,
      o_watchdog_en, o_watchdog_clock};
    chk(g & m, exp_f(c2, c3, osc, osc[0] ^ c3[0]) & m);
    chk({31'h0, o_powerup_done}, {31'h0, c2[2:1] == 2'h3});
    wb(1'h0, 16'h8008, 32'h0);
    chk(rd, {16'h0, c2});
    wb(1'h1, 16'h8008, ~rd);
    wb(1'h0, 16'h8008, 32'h0);
    chk(rd, {16'h0, c2});
    wb(1'h0, 16'h8009, 32'h0);
    chk(rd, {16'h0, c3});
    wb(1'h0, 16'h8000, 32'h0);
    chk(rd, 32'h0);
    d = $random(seed);
    wb(1'h1, 16'h8010, d);
    wb(1'h0, 16'h8010, 32'h0);
    chk(rd, {27'h0, d[4:0]});
    g = {28'h0, o_zero_cross_on, o_dac_range, o_brownout_en, o_watchdog_en};
    m = {28'h0, ~c2[10] | d[0], c2[8] & d[3], c2[7] | c2[6] & d[2], c3[6] | c3[5] & d[4]};
    chk(g, m);
    i_sleep <= 1'h1;
    repeat (4) @(posedge i_clk);
    g = {30'h0, o_brownout_en, o_watchdog_en};
    m = {30'h0, c2[6] & (c2[7] | d[2]), c3[5] & (c3[6] | d[4])};
    chk(g, m);
    i_sleep <= 1'h0;
    wb(1'h1, 16'h8012, 32'h1);
    g[0] = o_pin_select_locked;
    wb(1'h1, 16'h8012, 32'h4);
    wb(1'h1, 16'h8012, 32'h5);
    g[1] = o_pin_select_locked;
    wb(1'h1, 16'h8012, 32'h4);
    chk({29'h0, o_pin_select_locked, g[1:0]}, {29'h0, c2[11], 2'h2});
    wb(1'h1, 16'h8013, 32'h000003D2);
    wb(1'h1, 16'h8013, 32'h00000411);
    wb(1'h0, 16'h8013, 32'h0);
    m[2:0] = (c3[13:11] == 3'h7) ? 3'h1 : c3[13:11];
    m[5:3] = (c3[10:8] == 3'h7 || c3[10:8] < 3'h4) ? 3'h1 : c3[10:8];
    if (c3[10:8] == 3'h6) m[5:3] = 3'h7;
    m[10:6] = (c3[4:0] == 5'h1F) ? 5'h04 : c3[4:0];
    chk(rd, {19'h0, m[10:6], 1'h0, m[5:3], 1'h0, m[2:0]});
    g = {21'h0, o_watchdog_runtime_period, o_watchdog_window, o_watchdog_clock};
    chk(g, {21'h0, m[10:0]});
    i_stack_fault <= 1'h1;
    repeat (5) @(posedge i_clk);
    chk({31'h0, o_stack_reset}, {31'h0, c2[12]});
    i_stack_fault <= 1'h0;
    repeat (5) @(posedge i_clk);
    $display("test done at %0t", $time);
  endtask
  task automatic complete_run;
    $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    run(16'hFFFF, 16'hFFFF);
    run(16'h0000, 16'h0000);
    for (int t = 0; t < 12; t++) begin
      a = $random(seed);
      b = $random(seed);
      a[9] = 1'h0;
      run(a[15:0], b[15:0]);
    end
    run(16'hFFF9, 16'hFFFF);
    while (up_cyc < `CWD_PWRT_SHORT_MS * `CWD_CLK_MHZ * 1000 + 1) @(posedge i_clk);
    chk({31'h0, o_powerup_done}, 32'h0);
    @(posedge i_clk);
    chk({31'h0, o_powerup_done}, 32'h1);
    $display("power-up test done at %0t", $time);
    complete_run();
  end
  initial begin
    #2000000;
    fails++;
    complete_run();
  end
endmodule
